// file: hw/adcc_control.sv
// Purpose: channel select, go flag and result holding of a 10-bit converter
// Assumes: core, trigger and bus share clk; conversion core answers done
// Notes: result is right justified; all outputs come from flip-flops
//
// Notes on behaviour
// - writing go starts conversion on selected channel
// - go stays set while busy, clears when done
// - top two result bits in high register
// - low eight result bits in low register
// - codes 0-3 pick inputs, reserved connect nothing
// - compare trigger sets go, clears timer one
// - reset returns registers, stops any conversion
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module adcc_control #(
    parameter logic [4:0] CHAN_REF = 5'h1f,
    parameter logic [4:0] CHAN_TEMP = 5'h1d
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire adcc_pkg::adcc_req_s busReq,
    output adcc_pkg::adcc_rsp_s busRsp,
    // conversion core
    output adcc_pkg::adcc_core_s core,
    input wire logic convDone,
    input wire logic [adcc_pkg::RES_W-1:0] convData,
    // compare trigger unit and timer one
    input wire logic trigFire,
    output logic timerClear,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic enable;
        logic [adcc_pkg::CHAN_W-1:0] chan;
        logic go;
        logic [adcc_pkg::RES_W-1:0] res;
        logic [adcc_pkg::IRQ_W-1:0] stat;
        logic [adcc_pkg::IRQ_W-1:0] mask;
        adcc_pkg::adcc_rsp_s rsp;
        adcc_pkg::adcc_core_s core;
        logic timerClear;
        logic irq;
    } adcc_state_s;

    adcc_state_s s_q;
    adcc_state_s s_d;
    logic busy;
    logic doWrite;
    logic doRead;
    logic wrCtrl;

    function automatic logic [adcc_pkg::MUX_W-1:0] chanDecode(
        input logic [adcc_pkg::CHAN_W-1:0] code
    );
        logic [adcc_pkg::MUX_W-1:0] sel;
        sel = '0;
        if (code <= adcc_pkg::CHAN_EXT_LAST) begin
            sel[code[1:0]] = 1'b1;
        end else if (code == CHAN_REF) begin
            sel[adcc_pkg::MUX_REF] = 1'b1;
        end else if (code == adcc_pkg::CHAN_DAC) begin
            sel[adcc_pkg::MUX_DAC] = 1'b1;
        end else if (code == CHAN_TEMP) begin
            sel[adcc_pkg::MUX_TEMP] = 1'b1;
        end
        return sel;
    endfunction

    function automatic logic [7:0] ctrlView(input adcc_state_s st);
        ctrlView = {1'b0, st.chan, st.go, st.enable};
    endfunction

    // a write is taken on the second cycle, when waitrequest is low; read data is sampled on the first
    assign busy = (busReq.read || busReq.write) && !s_q.rsp.waitrequest;
    assign doWrite = busy && busReq.write && busReq.byteenable[0];
    assign doRead = (busReq.read || busReq.write) && s_q.rsp.waitrequest;
    assign wrCtrl = doWrite && busReq.address == adcc_pkg::ADDR_CTRL;

    wait_one_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (busReq.read || busReq.write) && s_q.rsp.waitrequest
        |=> !s_q.rsp.waitrequest)
        else $error("request not answered after one wait");

    wait_back_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !s_q.rsp.waitrequest |=> s_q.rsp.waitrequest)
        else $error("waitrequest low for more than a cycle");

    unmapped_err_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (busReq.read || busReq.write) && s_q.rsp.waitrequest
        && busReq.address > adcc_pkg::ADDR_IRQ_MASK
        |=> s_q.rsp.response == adcc_pkg::RESP_SLVERR
        && s_q.rsp.readdata == '0)
        else $error("unmapped access not refused");

    high_read_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (busReq.read || busReq.write) && s_q.rsp.waitrequest
        && busReq.address == adcc_pkg::ADDR_RES_HIGH
        |=> s_q.rsp.readdata == {30'h0, $past(s_q.res[9:8])})
        else $error("high result register read wrong");

    low_read_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (busReq.read || busReq.write) && s_q.rsp.waitrequest
        && busReq.address == adcc_pkg::ADDR_RES_LOW
        |=> s_q.rsp.readdata == {24'h0, $past(s_q.res[7:0])})
        else $error("low result register read wrong");

    ctrl_top_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (busReq.read || busReq.write) && s_q.rsp.waitrequest
        && busReq.address == adcc_pkg::ADDR_CTRL
        |=> s_q.rsp.readdata[31:7] == '0)
        else $error("control upper bits not zero");

    always_comb begin
        s_d = s_q;
        s_d.core.convStart = 1'b0;
        s_d.core.convAbort = 1'b0;
        s_d.timerClear = 1'b0;
        // bus handshake: one wait cycle, then completion
        s_d.rsp.waitrequest = 1'b1;
        if (doRead) begin
            s_d.rsp.waitrequest = 1'b0;
            s_d.rsp.response = adcc_pkg::RESP_OKAY;
            s_d.rsp.readdata = '0;
            unique case (busReq.address)
                adcc_pkg::ADDR_CTRL: s_d.rsp.readdata[7:0] = ctrlView(s_q);
                adcc_pkg::ADDR_RES_HIGH: begin
                    s_d.rsp.readdata[1:0] = s_q.res[9:8];
                end
                adcc_pkg::ADDR_RES_LOW: begin
                    s_d.rsp.readdata[7:0] = s_q.res[7:0];
                end
                adcc_pkg::ADDR_IRQ_STAT: begin
                    s_d.rsp.readdata[adcc_pkg::IRQ_W-1:0] = s_q.stat;
                end
                adcc_pkg::ADDR_IRQ_MASK: begin
                    s_d.rsp.readdata[adcc_pkg::IRQ_W-1:0] = s_q.mask;
                end
                default: s_d.rsp.response = adcc_pkg::RESP_SLVERR;
            endcase
        end
        // software writes
        if (wrCtrl) begin
            s_d.enable = busReq.writedata[adcc_pkg::BIT_ENABLE];
            s_d.chan = busReq.writedata[adcc_pkg::CHAN_LSB +:
                adcc_pkg::CHAN_W];
            if (busReq.writedata[adcc_pkg::BIT_GO] && s_d.enable) begin
                if (!s_q.go) begin
                    s_d.go = 1'b1;
                    s_d.core.convStart = 1'b1;
                end
            end else if (s_q.go) begin
                // clearing go or enable aborts the running conversion
                s_d.go = 1'b0;
                s_d.core.convAbort = 1'b1;
            end
        end
        if (doWrite && busReq.address == adcc_pkg::ADDR_IRQ_STAT) begin
            s_d.stat = s_q.stat &
                ~busReq.writedata[adcc_pkg::IRQ_W-1:0];
        end
        if (doWrite && busReq.address == adcc_pkg::ADDR_IRQ_MASK) begin
            s_d.mask = busReq.writedata[adcc_pkg::IRQ_W-1:0];
        end
        // completion: store result, drop go
        if (s_q.go && s_d.go && convDone) begin
            s_d.res = convData;
            s_d.go = 1'b0;
            s_d.stat[adcc_pkg::IRQ_DONE] = 1'b1;
        end
        // special event trigger, after the clears so a set wins
        if (trigFire) begin
            s_d.timerClear = 1'b1;
            s_d.stat[adcc_pkg::IRQ_TRIG] = 1'b1;
            if (s_d.enable && !s_d.go) begin
                s_d.go = 1'b1;
                s_d.core.convStart = 1'b1;
            end
        end
        s_d.core.convEnable = s_d.enable;
        s_d.core.muxSel = chanDecode(s_d.chan);
        s_d.irq = |(s_d.stat & s_d.mask);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // everything off but waitrequest and the mux, which selects input 0; any conversion dropped
            s_q <= '0;
            s_q.enable <= adcc_pkg::CTRL_RESET[adcc_pkg::BIT_ENABLE];
            s_q.go <= adcc_pkg::CTRL_RESET[adcc_pkg::BIT_GO];
            s_q.stat <= adcc_pkg::IRQ_RESET;
            s_q.mask <= adcc_pkg::IRQ_RESET;
            s_q.rsp.waitrequest <= 1'b1;
            s_q.core.muxSel <= adcc_pkg::MUX_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign busRsp = s_q.rsp;
    assign core = s_q.core;
    assign timerClear = s_q.timerClear;
    assign irq = s_q.irq;

    go_start_a: assert property (
        @(posedge clk) disable iff (!rstn)
        $rose(s_q.go) |-> s_q.core.convStart)
        else $error("go rose without a start pulse");

    done_clears_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.go && convDone && !trigFire && !wrCtrl |=> !s_q.go)
        else $error("go not cleared on completion");

    busy_holds_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.go && !convDone && !wrCtrl |=> s_q.go)
        else $error("go dropped while converting");

    res_high_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.go && convDone && !wrCtrl
        |=> s_q.res[9:8] == $past(convData[9:8]))
        else $error("high result bits wrong");

    res_low_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.go && convDone && !wrCtrl
        |=> s_q.res[7:0] == $past(convData[7:0]))
        else $error("low result bits wrong");

    mux_none_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.chan > adcc_pkg::CHAN_EXT_LAST && s_q.chan != CHAN_REF
        && s_q.chan != adcc_pkg::CHAN_DAC && s_q.chan != CHAN_TEMP
        |-> s_q.core.muxSel == '0)
        else $error("reserved code connected a channel");

    dac_route_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.chan == adcc_pkg::CHAN_DAC
        |-> s_q.core.muxSel == 7'h20)
        else $error("dac code not routed");

    off_idle_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !s_q.enable |-> !s_q.go && !s_q.core.convEnable)
        else $error("disabled converter still busy");

    trig_go_a: assert property (
        @(posedge clk) disable iff (!rstn)
        trigFire && s_q.enable && !s_q.go && !wrCtrl
        |=> s_q.go && s_q.timerClear
        ##1 s_q.timerClear == $past(trigFire))
        else $error("trigger did not start conversion");

    go_write_a: assert property (
        @(posedge clk) disable iff (!rstn)
        wrCtrl && busReq.writedata[adcc_pkg::BIT_GO]
        && busReq.writedata[adcc_pkg::BIT_ENABLE] && !s_q.go
        |=> s_q.go && s_q.core.convStart)
        else $error("go write did not start conversion");

    abort_pulse_a: assert property (
        @(posedge clk) disable iff (!rstn)
        wrCtrl && s_q.go && !(busReq.writedata[adcc_pkg::BIT_GO]
        && busReq.writedata[adcc_pkg::BIT_ENABLE])
        |=> s_q.core.convAbort)
        else $error("cleared go did not abort");

    done_sets_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.go && convDone && !wrCtrl
        |=> s_q.stat[adcc_pkg::IRQ_DONE])
        else $error("completion did not set status");

    res_hold_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !(s_q.go && convDone) |=> $stable(s_q.res))
        else $error("result changed without completion");

    stat_sticky_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.stat[adcc_pkg::IRQ_DONE]
        && !(doWrite && busReq.address == adcc_pkg::ADDR_IRQ_STAT)
        |=> s_q.stat[adcc_pkg::IRQ_DONE])
        else $error("done status lost without a clear");

    irq_level_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.irq == |(s_q.stat & s_q.mask))
        else $error("interrupt level wrong");

    enable_mirror_a: assert property (
        @(posedge clk) disable iff (!rstn)
        s_q.core.convEnable == s_q.enable)
        else $error("converter enable not mirrored");

    timer_clear_a: assert property (
        @(posedge clk) disable iff (!rstn)
        trigFire |=> s_q.timerClear && s_q.stat[adcc_pkg::IRQ_TRIG])
        else $error("trigger not seen");

    trig_off_a: assert property (
        @(posedge clk) disable iff (!rstn)
        trigFire && !s_q.enable && !wrCtrl |=> !s_q.go)
        else $error("trigger started a disabled converter");
endmodule
`default_nettype wire

// file: hw/adcc_pkg.sv
// Purpose: shared constants and carriers of the converter control block
// Assumes: 32-bit avalon-mm slave, byte addresses, one word per register
// Notes: register fields sit in the low byte of each word
package adcc_pkg;
    // register byte addresses
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_RES_HIGH = 5'h04;
    localparam logic [4:0] ADDR_RES_LOW = 5'h08;
    localparam logic [4:0] ADDR_IRQ_STAT = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
    // control register field positions; result and mux widths
    localparam int BIT_ENABLE = 0;
    localparam int BIT_GO = 1;
    localparam int CHAN_LSB = 2;
    localparam int CHAN_W = 5;
    localparam int RES_W = 10;
    localparam int RES_LOW_W = 8;
    localparam int MUX_W = 7;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TRIG = 1;
    localparam int IRQ_W = 2;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    localparam logic [MUX_W-1:0] MUX_RESET = 7'h01;
    // channel codes
    localparam logic [4:0] CHAN_EXT_LAST = 5'h03;
    localparam logic [4:0] CHAN_DAC = 5'h1e;
    // mux select positions for internal sources
    localparam int MUX_REF = 4;
    localparam int MUX_DAC = 5;
    localparam int MUX_TEMP = 6;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } adcc_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
        logic [1:0] response;
    } adcc_rsp_s;

    typedef struct packed {
        logic convEnable;
        logic convStart;
        logic convAbort;
        logic [MUX_W-1:0] muxSel;
    } adcc_core_s;
endpackage

// file: testbench/adcc_core_model.sv
// Purpose: conversion core seen from the control block
// Assumes: start pulse with enable high; lag plus one cycles to completion
// Notes: data line toggles when no result is valid
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control side
    input wire adcc_pkg::adcc_core_s core,
    input wire logic [9:0] sample,
    input wire logic [7:0] lag,
    output logic convDone,
    output logic [9:0] convData
);
    logic busy;
    logic [7:0] cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            convDone <= 1'b0;
            convData <= 10'h2aa;
        end else begin
            convDone <= 1'b0;
            convData <= ~convData;
            if (core.convStart && core.convEnable) begin
                busy <= 1'b1;
                cnt <= lag;
            end else if (core.convAbort || !core.convEnable) begin
                busy <= 1'b0;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'b0;
                convDone <= 1'b1;
                convData <= sample;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/adcc_control_tb.sv
// Purpose: self-checking bench of the converter control block
// Assumes: one wait cycle per access, core model on the far side
// Notes: random samples and lags from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module adcc_control_tb;
    logic clk, rstn, trigFire, timerClear, irq, convDone;
    adcc_pkg::adcc_req_s req;
    adcc_pkg::adcc_rsp_s rsp;
    adcc_pkg::adcc_core_s core;
    logic [9:0] convData, sample;
    logic [7:0] lag;
    logic [31:0] q, s;
    logic [1:0] rp;
    integer seed, miscompares, check_count, cycles, i;
    adcc_control adcc_control_inst (.clk(clk), .rstn(rstn), .busReq(req),
        .busRsp(rsp), .core(core), .convDone(convDone),
        .convData(convData), .trigFire(trigFire),
        .timerClear(timerClear), .irq(irq));
    adcc_core_model adcc_core_model_inst (.clk(clk), .rstn(rstn),
        .core(core), .sample(sample), .lag(lag), .convDone(convDone),
        .convData(convData));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [6:0] expm(input logic [4:0] c);
        if (c <= 5'h03) return 7'h01 << c;
        if (c == 5'h1f) return 7'h10;
        if (c == 5'h1e) return 7'h20;
        if (c == 5'h1d) return 7'h40;
        return 7'h00;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        req <= '{a, !w, w, {24'h0, d}, 4'h1};
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        rp = rsp.response;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task automatic waitgo();
        do bus(0, adcc_pkg::ADDR_CTRL, 8'h00); while (q[1] !== 1'b0);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        seed = 40855;
        {miscompares, check_count, cycles} = 0;
        rstn = 1'b0;
        req = '0;
        trigFire = 1'b0;
        sample = 10'h000;
        lag = 8'h04;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        #1 chk(core.muxSel, 7'h01);
        bus(0, adcc_pkg::ADDR_CTRL, 8'h00); chk(q, 0);
        for (i = 0; i < 32; i++) begin
            bus(1, adcc_pkg::ADDR_CTRL, {1'b1, i[4:0], 2'b00});
            #1 chk(core.muxSel, expm(i[4:0]));
            bus(0, adcc_pkg::ADDR_CTRL, 8'h00);
            chk(q, {i[4:0], 2'b00});
        end
        bus(1, adcc_pkg::ADDR_IRQ_MASK, 8'h01);
        for (i = 0; i < 6; i++) begin
            s = $random(seed);
            sample <= s[9:0];
            lag <= {2'b00, s[15:10]} + 8'h04;
            bus(1, adcc_pkg::ADDR_CTRL, {4'h0, s[17:16], 2'b11});
            #1 chk(core.muxSel, expm({3'h0, s[17:16]}));
            chk(core.convStart, 1);
            bus(0, adcc_pkg::ADDR_CTRL, 8'h00); chk(q[1], 1);
            waitgo();
            bus(0, adcc_pkg::ADDR_RES_HIGH, 8'h00); chk(q, s[9:8]);
            bus(0, adcc_pkg::ADDR_RES_LOW, 8'h00); chk(q, s[7:0]);
            bus(0, adcc_pkg::ADDR_IRQ_STAT, 8'h00); chk(q, 1);
            chk(irq, 1);
            bus(1, adcc_pkg::ADDR_IRQ_STAT, 8'h01);
            bus(0, adcc_pkg::ADDR_IRQ_STAT, 8'h00); chk(q, 0);
            chk(irq, 0);
        end
        bus(1, adcc_pkg::ADDR_IRQ_MASK, 8'h00);
        lag <= 8'h04;
        @(posedge clk) trigFire <= 1'b1;
        @(posedge clk) trigFire <= 1'b0;
        #1 chk(timerClear, 1);
        bus(0, adcc_pkg::ADDR_CTRL, 8'h00); chk(q[1], 1);
        waitgo();
        bus(0, adcc_pkg::ADDR_IRQ_STAT, 8'h00); chk(q, 3);
        chk(irq, 0);
        bus(1, adcc_pkg::ADDR_IRQ_MASK, 8'h03);
        @(posedge clk) #1 chk(irq, 1);
        bus(1, adcc_pkg::ADDR_IRQ_STAT, 8'h03);
        @(posedge clk) #1 chk(irq, 0);
        bus(0, 5'h14, 8'h00); chk(q, 0);
        chk(rp, 2'h2);
        lag <= 8'hff;
        bus(1, adcc_pkg::ADDR_CTRL, 8'h03);
        bus(1, adcc_pkg::ADDR_CTRL, 8'h01);
        #1 chk(core.convAbort, 1);
        bus(0, adcc_pkg::ADDR_CTRL, 8'h00); chk(q, 8'h01);
        bus(1, adcc_pkg::ADDR_CTRL, 8'h00);
        @(posedge clk) trigFire <= 1'b1;
        @(posedge clk) trigFire <= 1'b0;
        #1 chk(timerClear, 1);
        chk(irq, 1);
        bus(0, adcc_pkg::ADDR_CTRL, 8'h00); chk(q, 0);
        bus(1, adcc_pkg::ADDR_CTRL, 8'h03);
        @(posedge clk) rstn <= 1'b0;
        @(posedge clk) #1 chk(core.convEnable, 0);
        @(posedge clk) rstn <= 1'b1;
        bus(0, adcc_pkg::ADDR_CTRL, 8'h00); chk(q, 0);
        complete_run();
    end
endmodule
`default_nettype wire
